/* File: adc_serial_acquisition_sequencer_bench.sv */
// Self-checking bench joining host end and converter end over one link.
// Assumes converter waits shortened to 4 link clocks; FIFO depth 16.
`timescale 1ns/1ps
module adc_serial_acquisition_sequencer_bench;
    import asq_pkg::*;
    typedef struct {logic fast; logic done; logic [1:0] ch; logic [15:0] cnt;
        logic [15:0] base; int rx_want; int exp_want;} asq_row_t;
    localparam int LIMIT = 40000;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic link_nrst = 1'b0;
    logic start = 1'b0;
    logic fast = 1'b0;
    logic use_done = 1'b0;
    logic smp_ready = 1'b1;
    logic [1:0] ch = 2'h0;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] base = 16'h0000;
    logic [39:0] analog = {10'h3a5, 10'h15a, 10'h2c3, 10'h0f0};
    logic run, rx_ev, exp_ev, smp_valid, dev_fast;
    logic [1:0] dev_ch;
    logic [15:0] smp_addr;
    logic [9:0] smp_data;
    logic [25:0] got_q[$];
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int n_rx, n_exp, t_rx, gmin, gmax;
    time t_last = 0;
    time per = 0;
    asq_row_t rows[5];
    asq_row_t bp;

    always #(SYS_CLK_NS / 2.0) sys_clk = ~sys_clk;

    asq_link_if lnk();
    asq_host i_asq_host (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_ce(1'b1), .lnk(lnk.host),
        .i_start(start), .i_fast_mode(fast), .i_use_done(use_done), .i_channel(ch),
        .i_sample_count(cnt), .i_base_addr(base), .o_run(run),
        .o_receive_done_event(rx_ev), .o_wait_expiry_event(exp_ev), .o_smp_valid(smp_valid),
        .i_smp_ready(smp_ready), .o_smp_addr(smp_addr), .o_smp_data(smp_data));
    asq_device #(.CONV_SLOW(4), .CONV_FAST(4)) i_asq_device (.i_link_clk(lnk.transmit_clock),
        .i_nrst(link_nrst), .i_ce(1'b1), .lnk(lnk.device), .i_analog(analog),
        .o_fast_mode(dev_fast), .o_channel(dev_ch));
    asq_chk i_asq_chk (.transmit_clock(lnk.transmit_clock), .i_link_nrst(link_nrst),
        .i_run(run),
        .select_drive_output_n(lnk.select_drive_output_n), .frame_sync(lnk.frame_sync),
        .host_data(lnk.host_data), .result_data(lnk.result_data), .conv_done(lnk.conv_done));

    // Event tally, wait gaps, sample capture and hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (rx_ev === 1'b1)
        begin
            n_rx++;
            t_rx = cyc;
        end
        if (exp_ev === 1'b1)
        begin
            n_exp++;
            gmin = (cyc - t_rx < gmin) ? cyc - t_rx : gmin;
            gmax = (cyc - t_rx > gmax) ? cyc - t_rx : gmax;
        end
        if (smp_valid === 1'b1 && smp_ready)
            got_q.push_back({smp_addr, smp_data});
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            conclude();
        end
    end

    // Link clock period, to judge the serial rate
    always @(posedge lnk.transmit_clock)
    begin
        per = $time - t_last;
        t_last = $time;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    // Both resets; the host leaves first so the link clock runs for the converter
    task automatic do_reset();
        @(negedge sys_clk);
        nrst = 1'b0;
        link_nrst = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(run, 1'b0, "run in reset");
        chk(lnk.select_drive_output_n, 1'b1, "select in reset");
        chk(smp_valid, 1'b0, "valid in reset");
        nrst = 1'b1;
        repeat (3) @(posedge lnk.transmit_clock);
        @(negedge sys_clk);
        link_nrst = 1'b1;
    endtask : do_reset

    task automatic launch(input asq_row_t r);
        @(negedge sys_clk);
        {fast, use_done, ch, cnt, base} = {r.fast, r.done, r.ch, r.cnt, r.base};
        start = 1'b1;
        n_rx = 0;
        n_exp = 0;
        gmin = 1 << 30;
        gmax = 0;
        got_q.delete();
        @(negedge sys_clk);
        start = 1'b0;
    endtask : launch

    // Settle long enough that a stray slow-mode expiry would still be seen
    task automatic finish_wait();
        repeat (3) @(negedge sys_clk);
        while (run === 1'b1)
            @(negedge sys_clk);
        repeat (1100) @(negedge sys_clk);
    endtask : finish_wait

    task automatic check_row(input asq_row_t r);
        int w;
        w = r.fast ? int'(WAIT_FAST_CYC) : int'(WAIT_SLOW_CYC);
        chk(n_rx, r.rx_want, "frame count");
        chk(n_exp, r.exp_want, "expiry count");
        chk(got_q.size(), r.cnt, "sample count");
        foreach (got_q[i])
            chk(got_q[i], {r.base + 16'(i), analog[r.ch*10 +: 10]}, "sample");
        if (r.cnt != 0)
        begin
            chk(dev_fast, r.fast, "device mode");
            chk(dev_ch, r.ch, "device channel");
            chk(32'(per), r.fast ? SCLK_FAST_NS : SCLK_SLOW_NS, "link period");
        end
        if (!r.done && r.cnt != 0)
            chk(gmin >= w && gmax <= w + 3, 1'b1, "wait length");
    endtask : check_row

    task automatic conclude();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Ordinary cases: timer and done modes at both rates, a wrapping pointer, a zero count
    initial
    begin
        rows[0] = '{1'b1, 1'b0, 2'h1, 16'h0003, 16'h0100, 32'h5, 32'h4};
        rows[1] = '{1'b0, 1'b0, 2'h2, 16'h0002, 16'h0200, 32'h4, 32'h3};
        rows[2] = '{1'b1, 1'b1, 2'h3, 16'h0004, 16'hfffe, 32'h6, 32'h0};
        rows[3] = '{1'b0, 1'b1, 2'h0, 16'h0002, 16'h0300, 32'h4, 32'h0};
        rows[4] = '{1'b1, 1'b1, 2'h2, 16'h0000, 16'h0400, 32'h0, 32'h0};
        bp = '{1'b1, 1'b1, 2'h1, 16'h0012, 16'h0500, 32'h14, 32'h0};
        do_reset();
        foreach (rows[i])
        begin
            launch(rows[i]);
            finish_wait();
            check_row(rows[i]);
        end
        // Consumer stalls: FIFO fills, host holds off further frames
        smp_ready = 1'b0;
        launch(bp);
        repeat (3000) @(negedge sys_clk);
        chk(run, 1'b1, "stalled run");
        chk(smp_valid, 1'b1, "fifo holds");
        smp_ready = 1'b1;
        finish_wait();
        check_row(bp);
        // Reset in mid-run, then a clean run from the mode word again
        launch(rows[2]);
        repeat (150) @(negedge sys_clk);
        do_reset();
        launch(rows[0]);
        finish_wait();
        check_row(rows[0]);
        conclude();
    end
endmodule : adc_serial_acquisition_sequencer_bench

/* File: asq_chk.sv */
// Link checker for the acquisition sequencer: host end facing converter end.
// Assumes both ends share one link interface; sees its wires except the inverted done, plus the host run level and converter reset.
`timescale 1ns/1ps
module asq_chk (
    // Link clock and converter reset
    input wire logic transmit_clock,
    input wire logic i_link_nrst,
    // Host run level, low between acquisitions
    input wire logic i_run,
    // Link wires
    input wire logic select_drive_output_n,
    input wire logic frame_sync,
    input wire logic host_data,
    input wire logic result_data,
    input wire logic conv_done
);
    logic first_r;

    // Marks the first frame of each run, which must carry the mode word
    always_ff @(posedge transmit_clock)
    begin
        if (!i_link_nrst)
            first_r <= 1'h1;
        else if (!i_run)
            first_r <= 1'h1;
        else if (frame_sync)
            first_r <= 1'h0;
    end

    default clocking cb @(posedge transmit_clock);
    endclocking
    default disable iff (!i_link_nrst);

    // Sixteen link edges with the line low; split since repeats stop at 8
    sequence s_low16(sig);
        (!sig)[*8] ##1 (!sig)[*8];
    endsequence

    // Top of a mode word: 101x
    sequence s_mode_nibble;
        host_data ##1 !host_data ##1 host_data;
    endsequence

    a_sel_over_frame: assert property (
        frame_sync |-> !select_drive_output_n ##1 s_low16(select_drive_output_n))
        else $error("select not low across frame");
    a_sync_spacing: assert property (
        frame_sync |=> s_low16(frame_sync) ##1 (!frame_sync)[*4])
        else $error("frame sync too close");
    a_result_pad_zero: assert property (
        frame_sync |-> ##11 (!result_data)[*6])
        else $error("result pad bits not zero");
    a_sel_rise_after: assert property (
        $rose(select_drive_output_n) |-> $past(frame_sync, 17))
        else $error("select rose off the frame end");
    a_mode_word_first: assert property (
        frame_sync && first_r |=> s_mode_nibble)
        else $error("first frame lacks mode word");
    a_chan_word_later: assert property (
        frame_sync && !first_r |=> !host_data)
        else $error("later frame not a channel word");
    a_done_low_frame: assert property (
        frame_sync |=> s_low16(conv_done))
        else $error("done high during frame");
    a_done_rise_time: assert property (
        frame_sync |-> ##[17:30] $rose(conv_done))
        else $error("done did not rise after frame");
    a_done_held: assert property (
        $fell(conv_done) |-> $past(frame_sync))
        else $error("done fell outside frame start");
endmodule : asq_chk

/* File: asq_device.sv */
// Converter end: 10-bit serial converter clocked by the link clock; also the host's sample FIFO.
// Assumes host data and frame sync change on falling link clock edges.
`timescale 1ns/1ps
module asq_device #(
    parameter int CONV_SLOW = asq_pkg::CONV_SLOW_CYC,
    parameter int CONV_FAST = asq_pkg::CONV_FAST_CYC
) (
    // Link clock domain
    input wire logic i_link_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Link side
    asq_link_if.device lnk,
    // Analogue inputs, one word per channel
    input wire logic [asq_pkg::CHANNELS*asq_pkg::RESULT_BITS-1:0] i_analog,
    output logic o_fast_mode,
    output logic [asq_pkg::CH_W-1:0] o_channel
);
    import asq_pkg::*;

    typedef enum logic [1:0] {DV_IDLE, DV_SHIFT, DV_CONV} asq_dv_state_t;

    typedef struct packed {
        asq_dv_state_t state;
        logic [BIT_W-1:0] bitcnt;
        logic [CONV_W-1:0] conv_cnt;
        logic [FRAME_BITS-1:0] sh_out;
        logic [FRAME_BITS-1:0] sh_in;
        logic [RESULT_BITS-1:0] result;
        logic fast;
        logic [CH_W-1:0] chan;
        logic miso;
        logic done;
    } asq_dv_t;

    asq_dv_t r;
    asq_dv_t n;

    // Frame, decode and conversion sequencing
    always_comb
    begin
        n = r;
        unique case (r.state)
            DV_IDLE:
            begin
                if (!lnk.select_drive_output_n && lnk.frame_sync)
                begin
                    n.state = DV_SHIFT;
                    n.bitcnt = '0;
                    n.done = 1'h0;
                    n.miso = r.result[RESULT_BITS-1];
                    n.sh_out = {r.result[RESULT_BITS-2:0], 7'h00};
                end
            end
            DV_SHIFT:
            begin
                // Deselect mid-frame aborts without touching mode or channel
                if (lnk.select_drive_output_n)
                begin
                    n.state = DV_IDLE;
                end
                else
                begin
                    n.sh_in = {r.sh_in[FRAME_BITS-2:0], lnk.host_data};
                    n.miso = r.sh_out[FRAME_BITS-1];
                    n.sh_out = {r.sh_out[FRAME_BITS-2:0], 1'h0};
                    n.bitcnt = r.bitcnt + 5'h01;
                    if (r.bitcnt == 5'(FRAME_BITS - 1))
                    begin
                        if (n.sh_in[15:12] == CMD_MODE_FAST)
                            n.fast = 1'h1;
                        else if (n.sh_in[15:12] == CMD_MODE_SLOW)
                            n.fast = 1'h0;
                        else
                            n.chan = n.sh_in[CH_LSB+CH_W-1:CH_LSB];
                        n.state = DV_CONV;
                        n.conv_cnt = n.fast ? CONV_W'(CONV_FAST) : CONV_W'(CONV_SLOW);
                    end
                end
            end
            DV_CONV:
            begin
                n.conv_cnt = r.conv_cnt - 7'h01;
                if (r.conv_cnt == 7'h01)
                begin
                    n.result = i_analog[r.chan*RESULT_BITS +: RESULT_BITS];
                    n.done = 1'h1;
                    n.state = DV_IDLE;
                end
            end
            default:
            begin
                n.state = DV_IDLE;
            end
        endcase
    end

    // Result starts at zero, so the first reply after reset carries no sample
    always_ff @(posedge i_link_clk)
    begin
        if (!i_nrst)
            r <= '{state: DV_IDLE, default: '0};
        else if (i_ce)
            r <= n;
    end

    assign lnk.result_data = r.miso;
    assign lnk.conv_done = r.done;
    assign o_fast_mode = r.fast;
    assign o_channel = r.chan;

endmodule : asq_device

// Sample buffer for the host end, on the system clock
module asq_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    // Clock and control
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } asq_fifo_t;

    asq_fifo_t r;
    asq_fifo_t n;
    logic push;
    logic pop;

    assign o_in_ready = (r.cnt != CW'(DEPTH));
    assign o_out_valid = (r.cnt != '0);
    assign o_out_data = r.mem[r.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointers wrap explicitly so any depth works, not only powers of two
    always_comb
    begin
        n = r;
        if (push)
        begin
            n.mem[r.wp] = i_in_data;
            n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + PW'(1);
        end
        if (pop)
            n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + PW'(1);
        n.cnt = r.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
            r <= '0;
        else if (i_ce)
            r <= n;
    end

endmodule : asq_fifo

/* File: asq_host.sv */
// Host end: acquisition sequencer with link clock divider and sample FIFO.
// Assumes the converter samples host data on rising link clock edges.
// Function
// - Select converter before loading control word
// - One 16-bit full-duplex frame per exchange
// - Frame ends at 16th clock, then deselect
// - Mode word first, channel word afterwards
// - First two results invalid, accept from third
// - Timer wait 10 us fast, 25 us slow
// - Timer halted, started at frame end, stopped
// - Store sample, bump pointer, decrement counter
// - Counter exhausted: clear run, disable events
// - Inverted done interrupt starts next frame
// - Serial clock 2 MHz slow, 10 MHz fast
// - Fast mode only above 3.3 V supply
// - Frame plus conversion timing per mode
// - Converter done rises at conversion end
`timescale 1ns/1ps
module asq_host #(
    parameter int DEPTH = 16,
    parameter int ADDR_W = 16,
    parameter int CNT_W = 16
) (
    // System clock domain
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Link side
    asq_link_if.host lnk,
    // Acquisition setup
    input wire logic i_start,
    input wire logic i_fast_mode,
    input wire logic i_use_done,
    input wire logic [asq_pkg::CH_W-1:0] i_channel,
    input wire logic [CNT_W-1:0] i_sample_count,
    input wire logic [ADDR_W-1:0] i_base_addr,
    // Status and events
    output logic o_run,
    output logic o_receive_done_event,
    output logic o_wait_expiry_event,
    // Sample stream
    output logic o_smp_valid,
    input wire logic i_smp_ready,
    output logic [ADDR_W-1:0] o_smp_addr,
    output logic [asq_pkg::RESULT_BITS-1:0] o_smp_data
);
    import asq_pkg::*;

    typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_SHIFT, HS_FINISH, HS_STORE, HS_WAIT}
        asq_hs_state_t;

    typedef struct packed {
        asq_hs_state_t state;
        logic [DIV_W-1:0] div;
        logic sclk;
        logic sel_n;
        logic fs;
        logic mosi;
        logic [BIT_W-1:0] bitcnt;
        logic [FRAME_BITS-1:0] tx;
        logic [FRAME_BITS-1:0] control_word_store;
        logic [FRAME_BITS-1:0] rx;
        logic [TALLY_W-1:0] frame_tally;
        logic [TMR_W-1:0] wait_period;
        logic timer_run;
        logic [ADDR_W-1:0] sample_pointer;
        logic [CNT_W-1:0] remaining_sample_counter;
        logic fast;
        logic use_done;
        logic eoc_seen;
        logic run;
        logic rx_evt;
        logic exp_evt;
        logic miso_s1;
        logic miso_s2;
        logic miso_s3;
        logic miso_f;
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic done_f;
    } asq_hs_t;

    asq_hs_t r;
    asq_hs_t n;
    logic tick;
    logic rise;
    logic fall;
    logic miso_now;
    logic done_now;
    logic push_ready;
    logic [DIV_W-1:0] half;

    // Fast mode gets the faster serial clock; slow mode is the low-supply rate
    assign half = r.fast ? SCLK_FAST_HALF : SCLK_SLOW_HALF;
    assign tick = (r.div >= half - 8'h01); // A rate change past the end wraps at once
    assign rise = tick && !r.sclk;
    assign fall = tick && r.sclk;

    // A pin level counts once the second and third stages agree
    assign miso_now = (r.miso_s2 == r.miso_s3) ? r.miso_s3 : r.miso_f;
    assign done_now = (r.done_s2 == r.done_s3) ? r.done_s3 : r.done_f;

    // Sequencer, link clock divider, wait timer and pin synchronisers
    always_comb
    begin
        n = r;
        n.rx_evt = 1'h0;
        n.exp_evt = 1'h0;
        n.miso_s1 = lnk.result_data;
        n.miso_s2 = r.miso_s1;
        n.miso_s3 = r.miso_s2;
        n.miso_f = miso_now;
        n.done_s1 = lnk.done_interrupt_n;
        n.done_s2 = r.done_s1;
        n.done_s3 = r.done_s2;
        n.done_f = done_now;
        // Link clock runs free so the converter always sees edges
        n.div = tick ? '0 : r.div + 8'h01;
        if (tick)
            n.sclk = ~r.sclk;
        // Wait timer stops itself the moment it expires
        if (r.timer_run)
        begin
            if (r.wait_period == 11'h001)
            begin
                n.timer_run = 1'h0;
                n.exp_evt = r.run;
            end
            else
            begin
                n.wait_period = r.wait_period - 11'h001;
            end
        end
        unique case (r.state)
            HS_IDLE:
            begin
                if (i_start && i_sample_count != '0)
                begin
                    n.fast = i_fast_mode;
                    n.use_done = i_use_done;
                    n.sample_pointer = i_base_addr;
                    n.remaining_sample_counter = i_sample_count;
                    n.frame_tally = '0;
                    n.timer_run = 1'h0;
                    n.tx = i_fast_mode ? MODE_FAST_WORD : MODE_SLOW_WORD;
                    n.control_word_store = 16'h0000;
                    n.control_word_store[CH_LSB+CH_W-1:CH_LSB] = i_channel;
                    n.sel_n = 1'h0;
                    n.run = 1'h1;
                    n.state = HS_LEAD;
                end
            end
            HS_LEAD:
            begin
                if (fall)
                begin
                    n.fs = 1'h1;
                    n.bitcnt = '0;
                    n.eoc_seen = 1'h0;
                    n.state = HS_SHIFT;
                end
            end
            HS_SHIFT:
            begin
                if (fall)
                begin
                    n.fs = 1'h0;
                    n.mosi = r.tx[FRAME_BITS-1];
                    n.tx = {r.tx[FRAME_BITS-2:0], 1'h0};
                end
                if (rise && !r.fs)
                begin
                    n.rx = {r.rx[FRAME_BITS-2:0], miso_now};
                    n.bitcnt = r.bitcnt + 5'h01;
                    if (r.bitcnt == 5'(FRAME_BITS - 1))
                        n.state = HS_FINISH;
                end
            end
            HS_FINISH:
            begin
                n.sel_n = 1'h1;
                n.rx_evt = 1'h1;
                if (!r.use_done)
                begin
                    n.wait_period = r.fast ? WAIT_FAST_CYC : WAIT_SLOW_CYC;
                    n.timer_run = 1'h1;
                end
                if (r.frame_tally != VALID_TALLY)
                    n.frame_tally = r.frame_tally + 2'h1;
                n.state = (n.frame_tally == VALID_TALLY) ? HS_STORE : HS_WAIT;
            end
            HS_STORE:
            begin
                // A full FIFO holds the sequencer here, delaying the next frame
                if (push_ready)
                begin
                    n.sample_pointer = r.sample_pointer + ADDR_W'(1);
                    n.remaining_sample_counter = r.remaining_sample_counter - CNT_W'(1);
                    if (r.remaining_sample_counter == CNT_W'(1))
                    begin
                        n.run = 1'h0;
                        n.timer_run = 1'h0;
                        n.exp_evt = 1'h0;
                        n.state = HS_IDLE;
                    end
                    else
                    begin
                        n.state = HS_WAIT;
                    end
                end
            end
            HS_WAIT:
            begin
                if (r.use_done ? r.eoc_seen : !r.timer_run)
                begin
                    n.sel_n = 1'h0;
                    n.tx = r.control_word_store;
                    n.state = HS_LEAD;
                end
            end
            default:
            begin
                n.state = HS_IDLE;
            end
        endcase
        // End of conversion is latched so a stalled store cannot miss it; set wins
        if (!done_now && r.done_f && r.run)
            n.eoc_seen = 1'h1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
            r <= '{state: HS_IDLE, sel_n: 1'h1, miso_s1: 1'h0, done_s1: 1'h1,
                   done_s2: 1'h1, done_s3: 1'h1, done_f: 1'h1, default: '0};
        else if (i_ce)
            r <= n;
    end

    // Sample buffer between the sequencer and the consumer
    asq_fifo #(
        .WIDTH(ADDR_W + RESULT_BITS),
        .DEPTH(DEPTH)
    ) i_asq_fifo (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_in_valid(r.state == HS_STORE),
        .o_in_ready(push_ready),
        .i_in_data({r.sample_pointer, r.rx[FRAME_BITS-1 -: RESULT_BITS]}),
        .o_out_valid(o_smp_valid),
        .i_out_ready(i_smp_ready),
        .o_out_data({o_smp_addr, o_smp_data})
    );

    assign lnk.transmit_clock = r.sclk;
    assign lnk.select_drive_output_n = r.sel_n;
    assign lnk.frame_sync = r.fs;
    assign lnk.host_data = r.mosi;
    assign o_run = r.run;
    assign o_receive_done_event = r.rx_evt;
    assign o_wait_expiry_event = r.exp_evt;

endmodule : asq_host

/* File: asq_link_if.sv */
// Link between the acquisition host and the serial converter.
// Carries the external inverter that turns conversion done into an interrupt.
`timescale 1ns/1ps
interface asq_link_if;
    logic transmit_clock;
    logic select_drive_output_n;
    logic frame_sync;
    logic host_data;
    logic result_data;
    logic conv_done;
    logic done_interrupt_n;

    // Inverter between converter done and host interrupt input
    assign done_interrupt_n = ~conv_done;

    modport host (
        output transmit_clock,
        output select_drive_output_n,
        output frame_sync,
        output host_data,
        input result_data,
        input done_interrupt_n
    );

    modport device (
        input transmit_clock,
        input select_drive_output_n,
        input frame_sync,
        input host_data,
        output result_data,
        output conv_done
    );
endinterface : asq_link_if

/* File: asq_pkg.sv */
// Shared constants for the serial converter acquisition sequencer.
// Assumes a 40 MHz system clock at the host end and a host-made link clock.
package asq_pkg;

    // Frame and data layout
    localparam int FRAME_BITS = 16;
    localparam int RESULT_BITS = 10;
    localparam int CHANNELS = 4;
    localparam int CH_W = 2;
    localparam int BIT_W = 5;
    localparam int DIV_W = 8;
    localparam int TMR_W = 11;
    localparam int CONV_W = 7;
    localparam int TALLY_W = 2;
    localparam logic [TALLY_W-1:0] VALID_TALLY = 2'h3;

    // Control word codes; the top nibble selects the command
    localparam logic [3:0] CMD_MODE_FAST = 4'ha;
    localparam logic [3:0] CMD_MODE_SLOW = 4'hb;
    localparam logic [15:0] MODE_FAST_WORD = {CMD_MODE_FAST, 12'h000};
    localparam logic [15:0] MODE_SLOW_WORD = {CMD_MODE_SLOW, 12'h000};
    localparam int CH_LSB = 12;

    // System clock and serial clock rates
    localparam int SYS_CLK_NS = 25;
    localparam int SCLK_SLOW_NS = 500;
    localparam int SCLK_FAST_NS = 100;
    localparam logic [DIV_W-1:0] SCLK_SLOW_HALF = DIV_W'(SCLK_SLOW_NS / (2 * SYS_CLK_NS));
    localparam logic [DIV_W-1:0] SCLK_FAST_HALF = DIV_W'(SCLK_FAST_NS / (2 * SYS_CLK_NS));

    // Worst-case conversion waits, rounded up to whole system cycles
    localparam int WAIT_FAST_NS = 10000;
    localparam int WAIT_SLOW_NS = 25000;
    localparam logic [TMR_W-1:0] WAIT_FAST_CYC =
        TMR_W'((WAIT_FAST_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [TMR_W-1:0] WAIT_SLOW_CYC =
        TMR_W'((WAIT_SLOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

    // Frame plus conversion time per mode; the conversion part alone in link clocks at the matching serial rates
    localparam int XFER_SLOW_NS = 20000;
    localparam int XFER_FAST_NS = 7700;
    localparam int CONV_SLOW_CYC = XFER_SLOW_NS / SCLK_SLOW_NS - FRAME_BITS;
    localparam int CONV_FAST_CYC = XFER_FAST_NS / SCLK_FAST_NS - FRAME_BITS;

endpackage : asq_pkg
